// File: host_bus_model.sv
`default_nettype none

module host_bus_model (
  input  wire logic        clk,
  output var  logic        cs_b,
  output var  logic        rd_b,
  output var  logic        wr_b,
  output var  logic [4:0]  addr,
  output var  logic [15:0] sd_in,
  input  wire logic        sd_oe,
  input  wire logic [15:0] sd_out
);
  timeunit 1ns;
  timeprecision 100ps;

  // Bus idle at time zero
  initial begin
    {cs_b, rd_b, wr_b} = 3'h7;
    addr = 5'h00;
    sd_in = 16'h0000;
  end

  // Strobe low 4 cycles, then 5 idle cycles with address still held
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    addr = a;
    sd_in = d;
    {cs_b, wr_b} = 2'h0;
    repeat (4) @(negedge clk);
    {cs_b, wr_b} = 2'h3;
    repeat (5) @(negedge clk);
    sd_in = ~d; // Released bus never shows the old value
  endtask : wr

  // No ready pin: wait for the drive enable, take data a cycle later
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    int n;
    @(negedge clk);
    addr = a;
    {cs_b, rd_b} = 2'h0;
    d = 'x;
    n = 0;
    while (sd_oe !== 1'b1 && n < 8) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
    if (sd_oe === 1'b1) d = sd_out;
    @(negedge clk);
    {cs_b, rd_b} = 2'h3;
    repeat (4) @(negedge clk);
  endtask : rd

endmodule : host_bus_model

`default_nettype wire

// File: mac_regs_pkg.sv
`default_nettype none

package mac_regs_pkg;

  // Bus and register widths
  localparam int ADDR_W = 5;
  localparam int BYTE_W = 8;
  localparam int WORD_W = 16;
  localparam int REG_COUNT = 32;

  // Offsets common to every page
  localparam logic [4:0] OFF_COMMAND    = 5'h00;
  localparam logic [4:0] OFF_DATA_LO    = 5'h10;
  localparam logic [4:0] OFF_DATA_HI    = 5'h11;
  localparam logic [4:0] OFF_GAP_ONE    = 5'h12;
  localparam logic [4:0] OFF_GAP_TWO    = 5'h13;
  localparam logic [4:0] OFF_MII_EEPROM = 5'h14;
  localparam logic [4:0] OFF_BUF_TYPE   = 5'h15;
  localparam logic [4:0] OFF_IFG        = 5'h16;
  localparam logic [4:0] OFF_DEV_STATUS = 5'h17;
  localparam logic [4:0] OFF_MFS_LOW    = 5'h18;
  localparam logic [4:0] OFF_MFS_HIGH   = 5'h19;
  localparam logic [4:0] OFF_FLOW       = 5'h1a;
  localparam logic [4:0] OFF_MAC_CFG    = 5'h1b;
  localparam logic [4:0] OFF_TX_END     = 5'h1c;
  localparam logic [4:0] OFF_VLAN_HIGH  = 5'h1d;
  localparam logic [4:0] OFF_BYTE_ORDER = 5'h1e;
  localparam logic [4:0] OFF_RESET_WAKE = 5'h1f;

  // Paged window and page zero offsets
  localparam logic [4:0] OFF_PAGED_FIRST = 5'h01;
  localparam logic [4:0] OFF_PAGED_LAST  = 5'h0f;
  localparam logic [4:0] OFF_RX_START    = 5'h01;
  localparam logic [4:0] OFF_RX_STOP     = 5'h02;
  localparam logic [4:0] OFF_RX_BOUNDARY = 5'h03;
  localparam logic [4:0] OFF_TX_PAGE     = 5'h04;
  localparam logic [4:0] OFF_TX_COUNT_LO = 5'h05;
  localparam logic [4:0] OFF_TX_COUNT_HI = 5'h06;
  localparam logic [4:0] OFF_INT_STATUS  = 5'h07;
  localparam logic [4:0] OFF_REMOTE_LO   = 5'h08;
  localparam logic [4:0] OFF_REMOTE_HI   = 5'h09;
  localparam logic [4:0] OFF_RCOUNT_LO   = 5'h0a;
  localparam logic [4:0] OFF_RCOUNT_HI   = 5'h0b;
  localparam logic [4:0] OFF_RX_CFG      = 5'h0c;
  localparam logic [4:0] OFF_TX_CFG      = 5'h0d;
  localparam logic [4:0] OFF_DATA_CFG    = 5'h0e;
  localparam logic [4:0] OFF_INT_MASK    = 5'h0f;

  // Fields and reset values
  localparam int PAGE_SEL_HI = 7;
  localparam int PAGE_SEL_LO = 6;
  localparam logic [1:0] PAGE_ZERO     = 2'h0;
  localparam int PORT_WIDTH_BIT         = 0;
  localparam logic [7:0] COMMAND_RESET  = 8'h21;
  localparam logic [7:0] STORE_RESET    = 8'h00;
  localparam logic [7:0] INT_RESET      = 8'h00;
  localparam logic [7:0] MFS_HIGH_MASK  = 8'h0f;

  // Host pins as sampled through the synchroniser
  typedef struct packed {
    logic             cs_b;
    logic             rd_b;
    logic             wr_b;
    logic [4:0]       addr;
    logic [15:0]      wdata;
  } host_pins_type;

  // State reported by the MAC engines
  typedef struct packed {
    logic [7:0]  tx_status;
    logic [7:0]  collision_count;
    logic [7:0]  rx_current_page_view;
    logic [15:0] remote_current_addr;
    logic [7:0]  rx_status;
    logic [7:0]  alignment_error_tally;
    logic [7:0]  crc_error_tally;
    logic [7:0]  lost_frame_tally;
    logic [7:0]  device_status;
    logic [7:0]  tx_end_page;
    logic [7:0]  interrupt_events;
  } core_status_type;

  // Settings handed to the MAC engines
  typedef struct packed {
    logic [7:0]  command_reg;
    logic [7:0]  rx_ring_start_page;
    logic [7:0]  rx_ring_stop_page;
    logic [7:0]  rx_boundary_pointer;
    logic [7:0]  tx_start_page;
    logic [15:0] tx_byte_count;
    logic [15:0] remote_start_addr;
    logic [15:0] remote_count;
    logic [7:0]  rx_config;
    logic [7:0]  tx_config;
    logic [7:0]  data_config;
    logic [7:0]  interrupt_mask;
    logic [7:0]  interrupt_status;
    logic [7:0]  gap_segment_one;
    logic [7:0]  gap_segment_two;
    logic [7:0]  mii_eeprom_access;
    logic [7:0]  buffer_type_config;
    logic [7:0]  interframe_gap;
    logic [7:0]  jam_limit_count;
    logic [11:0] max_frame_size;
    logic [7:0]  flow_control;
    logic [7:0]  mac_config;
    logic [15:0] vlan_tag;
    logic [7:0]  byte_order;
    logic        port_width_select;
  } core_config_type;

endpackage : mac_regs_pkg

`default_nettype wire

// File: mac_regs_properties.sv
`default_nettype none

module mac_regs_properties (
  input wire logic                          CLK,
  input wire logic                          RST_B,
  input wire logic                          CS_B,
  input wire logic                          RD_B,
  input wire logic                          WR_B,
  input wire logic [4:0]                    ADDR,
  input wire logic [15:0]                   SD_OUT,
  input wire logic                          SD_OE,
  input wire mac_regs_pkg::core_config_type CORE_CONFIG,
  input wire logic                          DP_READ_PULSE,
  input wire logic                          DP_WRITE_PULSE,
  input wire logic                          SOFT_RESET_PULSE,
  input wire logic                          HOST_WAKEUP_PULSE
);
  import mac_regs_pkg::*;

  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);

  // Decoded views of the current access
  wire logic page_zero = CORE_CONFIG.command_reg[7:6] == 2'h0;
  wire logic paged     = (ADDR != 5'h00) && !ADDR[4];
  wire logic port_addr = ADDR[4:1] == 4'h8;
  wire logic reserved  = (page_zero && (ADDR == 5'h0a || ADDR == 5'h0b))
                         || ADDR == 5'h1d || ADDR == 5'h1e;

  // Read data lands one cycle after the read is seen
  sequence read_start;
    $rose(SD_OE);
  endsequence

  AST_NARROW_READ: assert property (read_start ##0 !port_addr |=>
    SD_OUT[15:8] == 8'h00) else $error("upper byte set on narrow read");
  AST_NARROW_PORT: assert property (read_start ##0 (port_addr &&
    !CORE_CONFIG.port_width_select) |=> SD_OUT[15:8] == 8'h00)
    else $error("upper byte set in byte port mode");
  AST_PAGED_OFF: assert property (read_start ##0 (paged &&
    !page_zero) |=> SD_OUT == 16'h0000) else $error("page 1-3 read not 0");
  AST_PAGE_READ: assert property (read_start ##0 ADDR == 5'h00 |=>
    SD_OUT[7:0] == CORE_CONFIG.command_reg) else $error("command read");
  AST_RESERVED_READ: assert property (read_start ##0 reserved |=>
    SD_OUT == 16'h0000) else $error("reserved read not zero");
  AST_FRAME_HIGH: assert property (read_start ##0 ADDR == 5'h19 |=>
    SD_OUT[7:4] == 4'h0) else $error("frame size high nibble set");
  AST_PORT_READ: assert property (DP_READ_PULSE |-> port_addr &&
    !RD_B && !CS_B ##1 !DP_READ_PULSE) else $error("port read pulse");
  AST_PORT_WRITE: assert property (DP_WRITE_PULSE |-> port_addr &&
    WR_B ##1 !DP_WRITE_PULSE) else $error("port write pulse");
  AST_SOFT_RESET: assert property (SOFT_RESET_PULSE |->
    ADDR == 5'h1f && !RD_B ##1 !SOFT_RESET_PULSE) else $error("reset pulse");
  AST_WAKEUP: assert property (HOST_WAKEUP_PULSE |-> ADDR == 5'h1f
    ##1 !HOST_WAKEUP_PULSE) else $error("wakeup pulse");

endmodule : mac_regs_properties

bind paged_mac_register_decoder mac_regs_properties i_props (
  .CLK(CLK), .RST_B(RST_B), .CS_B(CS_B), .RD_B(RD_B), .WR_B(WR_B),
  .ADDR(ADDR), .SD_OUT(SD_OUT), .SD_OE(SD_OE), .CORE_CONFIG(CORE_CONFIG),
  .DP_READ_PULSE(DP_READ_PULSE), .DP_WRITE_PULSE(DP_WRITE_PULSE),
  .SOFT_RESET_PULSE(SOFT_RESET_PULSE), .HOST_WAKEUP_PULSE(HOST_WAKEUP_PULSE)
);

`default_nettype wire

// File: paged_mac_register_decoder.sv
// Notes on behaviour
// R01: Every register is eight bits wide except the data port.
// R02: Data port is 8 or 16 bits, per port width select in data_config.
// R03: Offsets 01h-0Fh follow the page select; 00h and 10h-1Fh do not.
// R04: Page select is command bits 7:6; page zero after reset.
// R05: Page zero 01h-03h read and write ring start, stop, boundary.
// R06: Page zero 04h reads transmit status, writes transmit start page.
// R07: Page zero 05h/06h read collisions/current page, write tx count.
// R08: Page zero 07h reads and writes interrupt status.
// R09: Page zero 08h/09h read current remote address, write start address.
// R10: Page zero 0Ah/0Bh write remote byte count; reads are reserved.
// R11: Page zero 0Ch reads receive status, writes receive configuration.
// R12: Page zero 0Dh-0Fh read tallies, write tx, data config and mask.
// R13: Offsets 10h and 11h both reach the data port.
// R14: Offsets 12h-16h are read/write gap, MII/EEPROM, buffer type, gap.
// R15: Offset 17h reads device status, writes jam limit count.
// R16: Max frame size is 12 bits over offsets 18h and 19h.
// R17: Offsets 1Ah and 1Bh are read/write flow control and MAC config.
// R18: 1Ch reads tx end page, writes VLAN byte 0; 1Dh writes byte 1.
// R19: Offset 1Eh is write-only byte order; reads are reserved.
// R20: Reading 1Fh fires software reset; writing fires host wake-up.
// R21: Reserved reads give zero with no effect; reserved writes ignored.
// R22: Host picks the page before paged access, back to zero after.

`default_nettype none

module paged_mac_register_decoder (
  input  wire logic                          CLK,
  input  wire logic                          RST_B,
  input  wire logic                          CS_B,
  input  wire logic                          RD_B,
  input  wire logic                          WR_B,
  input  wire logic [4:0]                    ADDR,
  input  wire logic [15:0]                   SD_IN,
  output var  logic [15:0]                   SD_OUT,
  output var  logic                          SD_OE,
  input  wire mac_regs_pkg::core_status_type CORE_STATUS,
  output var  mac_regs_pkg::core_config_type CORE_CONFIG,
  input  wire logic [15:0]                   DP_RDATA,
  output var  logic [15:0]                   DP_WDATA,
  output var  logic                          DP_READ_PULSE,
  output var  logic                          DP_WRITE_PULSE,
  output var  logic                          SOFT_RESET_PULSE,
  output var  logic                          HOST_WAKEUP_PULSE
);

  import mac_regs_pkg::*;

  // True for the offsets whose meaning depends on the page
  function automatic logic paged_offset(input logic [4:0] a);
    paged_offset = (a >= OFF_PAGED_FIRST) && (a <= OFF_PAGED_LAST);
  endfunction : paged_offset

  // True for offsets that reach the data port
  function automatic logic data_port_offset(input logic [4:0] a);
    data_port_offset = (a == OFF_DATA_LO) || (a == OFF_DATA_HI);
  endfunction : data_port_offset

  // True where a write lands in the plain storage array
  function automatic logic stored_offset(input logic [4:0] a);
    stored_offset = (paged_offset(a) && (a != OFF_INT_STATUS)) ||
                    ((a >= OFF_GAP_ONE) && (a <= OFF_BYTE_ORDER));
  endfunction : stored_offset

  host_pins_type pins_raw;
  host_pins_type pins_meta_reg;
  host_pins_type pins_sync_reg;
  host_pins_type pins_prev_reg;

  logic [7:0]  command_reg;
  logic [7:0]  command_next;
  logic [7:0]  int_status_reg;
  logic [7:0]  int_status_next;
  logic [7:0]  store_reg [0:REG_COUNT-1];
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic [15:0] dp_wdata_reg;
  logic        dp_read_reg;
  logic        dp_write_reg;
  logic        soft_reset_reg;
  logic        wakeup_reg;

  logic [1:0]  page_select;
  logic        port_width_select;
  logic        rd_active;
  logic        rd_was_active;
  logic        rd_start;
  logic        wr_active;
  logic        wr_was_active;
  logic        wr_end;
  logic [4:0]  rd_addr;
  logic [4:0]  wr_addr;
  logic [15:0] wr_data;
  logic [7:0]  wr_byte;
  logic        rd_page_ok;
  logic        wr_page_ok;
  logic        wr_store;
  logic        wr_command;
  logic        wr_int_status;
  logic        wr_data_port;
  logic        rd_data_port;
  logic        rd_reset_hit;
  logic        wr_wake_hit;
  logic [7:0]  rd_byte;
  logic [15:0] dp_read_word;

  // Host pins come from another clock domain; two flops before any use
  assign pins_raw = '{cs_b: CS_B, rd_b: RD_B, wr_b: WR_B,
                      addr: ADDR, wdata: SD_IN};

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      pins_meta_reg <= '{cs_b: 1'b1, rd_b: 1'b1, wr_b: 1'b1,
                         addr: '0, wdata: '0};
      pins_sync_reg <= '{cs_b: 1'b1, rd_b: 1'b1, wr_b: 1'b1,
                         addr: '0, wdata: '0};
      pins_prev_reg <= '{cs_b: 1'b1, rd_b: 1'b1, wr_b: 1'b1,
                         addr: '0, wdata: '0};
    end else begin
      pins_meta_reg <= pins_raw;
      pins_sync_reg <= pins_meta_reg;
      pins_prev_reg <= pins_sync_reg;
    end
  end

  // Strobe edges; a write acts at its trailing edge so data has settled
  assign rd_active     = !pins_sync_reg.cs_b && !pins_sync_reg.rd_b;
  assign rd_was_active = !pins_prev_reg.cs_b && !pins_prev_reg.rd_b;
  assign rd_start      = rd_active && !rd_was_active;
  assign wr_active     = !pins_sync_reg.cs_b && !pins_sync_reg.wr_b;
  assign wr_was_active = !pins_prev_reg.cs_b && !pins_prev_reg.wr_b;
  assign wr_end        = wr_was_active && !wr_active;
  assign rd_addr       = pins_sync_reg.addr;
  assign wr_addr       = pins_prev_reg.addr;
  assign wr_data       = pins_prev_reg.wdata;
  assign wr_byte       = wr_data[BYTE_W-1:0]; // R01

  // Page select steers only the paged window
  assign page_select = command_reg[PAGE_SEL_HI:PAGE_SEL_LO]; // R04
  assign rd_page_ok  = !paged_offset(rd_addr) ||
                       (page_select == PAGE_ZERO); // R03
  assign wr_page_ok  = !paged_offset(wr_addr) ||
                       (page_select == PAGE_ZERO); // R03

  // Pages one to three are not built here, so they act as reserved
  assign wr_store      = wr_end && wr_page_ok && stored_offset(wr_addr); // R21
  assign wr_command    = wr_end && (wr_addr == OFF_COMMAND);
  assign wr_int_status = wr_end && wr_page_ok &&
                         (wr_addr == OFF_INT_STATUS); // R08
  assign wr_data_port  = wr_end && data_port_offset(wr_addr); // R13
  assign rd_data_port  = rd_start && data_port_offset(rd_addr); // R13
  assign rd_reset_hit  = rd_start && (rd_addr == OFF_RESET_WAKE); // R20
  assign wr_wake_hit   = wr_end && (wr_addr == OFF_RESET_WAKE); // R20

  // Command register holds the page select among its fields
  assign command_next = wr_command ? wr_byte : command_reg;

  // Interrupt status: writing a one clears, a new event beats the clear
  assign int_status_next = (int_status_reg &
                            ~(wr_int_status ? wr_byte : INT_RESET)) |
                           CORE_STATUS.interrupt_events; // R08

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      command_reg    <= COMMAND_RESET; // R04
      int_status_reg <= INT_RESET;
    end else begin
      command_reg    <= command_next;
      int_status_reg <= int_status_next;
    end
  end

  // Write-side storage, one byte per offset
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      for (int i = 0; i < REG_COUNT; i++) begin
        store_reg[i] <= STORE_RESET;
      end
    end else if (wr_store) begin
      store_reg[wr_addr] <= wr_byte; // R05 R06 R07 R09 R10 R11 R12 R14
    end
  end

  // Width select lives in data_config
  assign port_width_select =
    store_reg[OFF_DATA_CFG][PORT_WIDTH_BIT]; // R02

  // Read selection for the byte-wide registers
  always_comb begin
    rd_byte = '0;
    if (rd_page_ok) begin // R03
      case (rd_addr)
        OFF_COMMAND:     rd_byte = command_reg;
        OFF_RX_START,
        OFF_RX_STOP,
        OFF_RX_BOUNDARY: rd_byte = store_reg[rd_addr]; // R05
        OFF_TX_PAGE:     rd_byte = CORE_STATUS.tx_status; // R06
        OFF_TX_COUNT_LO: rd_byte = CORE_STATUS.collision_count; // R07
        OFF_TX_COUNT_HI: rd_byte = CORE_STATUS.rx_current_page_view; // R07
        OFF_INT_STATUS:  rd_byte = int_status_reg; // R08
        OFF_REMOTE_LO:
          rd_byte = CORE_STATUS.remote_current_addr[7:0]; // R09
        OFF_REMOTE_HI:
          rd_byte = CORE_STATUS.remote_current_addr[15:8]; // R09
        OFF_RX_CFG:      rd_byte = CORE_STATUS.rx_status; // R11
        OFF_TX_CFG:      rd_byte = CORE_STATUS.alignment_error_tally; // R12
        OFF_DATA_CFG:    rd_byte = CORE_STATUS.crc_error_tally; // R12
        OFF_INT_MASK:    rd_byte = CORE_STATUS.lost_frame_tally; // R12
        OFF_GAP_ONE,
        OFF_GAP_TWO,
        OFF_MII_EEPROM,
        OFF_BUF_TYPE,
        OFF_IFG:         rd_byte = store_reg[rd_addr]; // R14
        OFF_DEV_STATUS:  rd_byte = CORE_STATUS.device_status; // R15
        OFF_MFS_LOW:     rd_byte = store_reg[rd_addr]; // R16
        OFF_MFS_HIGH:    rd_byte = store_reg[rd_addr] & MFS_HIGH_MASK; // R16
        OFF_FLOW,
        OFF_MAC_CFG:     rd_byte = store_reg[rd_addr]; // R17
        OFF_TX_END:      rd_byte = CORE_STATUS.tx_end_page; // R18
        default:         rd_byte = '0; // R10 R18 R19 R21
      endcase
    end
  end

  // Narrow data port drives only the low lane
  assign dp_read_word = port_width_select ? DP_RDATA :
                        {{BYTE_W{1'b0}}, DP_RDATA[BYTE_W-1:0]}; // R02

  // Read word is caught once at the strobe's leading edge
  assign rdata_next = !rd_start ? rdata_reg :
                      data_port_offset(rd_addr) ? dp_read_word :
                      {{BYTE_W{1'b0}}, rd_byte}; // R01

  // Registered read data and one-cycle side-effect pulses
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      rdata_reg      <= '0;
      dp_wdata_reg   <= '0;
      dp_read_reg    <= 1'b0;
      dp_write_reg   <= 1'b0;
      soft_reset_reg <= 1'b0;
      wakeup_reg     <= 1'b0;
    end else begin
      rdata_reg      <= rdata_next;
      if (wr_data_port) begin
        dp_wdata_reg <= port_width_select ? wr_data :
                        {{BYTE_W{1'b0}}, wr_byte}; // R02
      end
      dp_read_reg    <= rd_data_port;
      dp_write_reg   <= wr_data_port;
      soft_reset_reg <= rd_reset_hit; // R20
      wakeup_reg     <= wr_wake_hit; // R20
    end
  end

  // Bus turns around only while a selected read is under way
  assign SD_OE  = rd_active;
  assign SD_OUT = rdata_reg;

  assign DP_WDATA          = dp_wdata_reg;
  assign DP_READ_PULSE     = dp_read_reg;
  assign DP_WRITE_PULSE    = dp_write_reg;
  assign SOFT_RESET_PULSE  = soft_reset_reg;
  assign HOST_WAKEUP_PULSE = wakeup_reg;

  // Settings to the engines, straight from the storage flops
  assign CORE_CONFIG.command_reg         = command_reg;
  assign CORE_CONFIG.rx_ring_start_page  = store_reg[OFF_RX_START];
  assign CORE_CONFIG.rx_ring_stop_page   = store_reg[OFF_RX_STOP];
  assign CORE_CONFIG.rx_boundary_pointer = store_reg[OFF_RX_BOUNDARY];
  assign CORE_CONFIG.tx_start_page       = store_reg[OFF_TX_PAGE];
  assign CORE_CONFIG.tx_byte_count       = {store_reg[OFF_TX_COUNT_HI],
                                            store_reg[OFF_TX_COUNT_LO]};
  assign CORE_CONFIG.remote_start_addr   = {store_reg[OFF_REMOTE_HI],
                                            store_reg[OFF_REMOTE_LO]};
  assign CORE_CONFIG.remote_count        = {store_reg[OFF_RCOUNT_HI],
                                            store_reg[OFF_RCOUNT_LO]};
  assign CORE_CONFIG.rx_config           = store_reg[OFF_RX_CFG];
  assign CORE_CONFIG.tx_config           = store_reg[OFF_TX_CFG];
  assign CORE_CONFIG.data_config         = store_reg[OFF_DATA_CFG];
  assign CORE_CONFIG.interrupt_mask      = store_reg[OFF_INT_MASK];
  assign CORE_CONFIG.interrupt_status    = int_status_reg;
  assign CORE_CONFIG.gap_segment_one     = store_reg[OFF_GAP_ONE];
  assign CORE_CONFIG.gap_segment_two     = store_reg[OFF_GAP_TWO];
  assign CORE_CONFIG.mii_eeprom_access   = store_reg[OFF_MII_EEPROM];
  assign CORE_CONFIG.buffer_type_config  = store_reg[OFF_BUF_TYPE];
  assign CORE_CONFIG.interframe_gap      = store_reg[OFF_IFG];
  assign CORE_CONFIG.jam_limit_count     = store_reg[OFF_DEV_STATUS]; // R15
  // Only four bits of the high byte exist, the rest is dropped
  assign CORE_CONFIG.max_frame_size      = {store_reg[OFF_MFS_HIGH][3:0],
                                            store_reg[OFF_MFS_LOW]}; // R16
  assign CORE_CONFIG.flow_control        = store_reg[OFF_FLOW];
  assign CORE_CONFIG.mac_config          = store_reg[OFF_MAC_CFG];
  assign CORE_CONFIG.vlan_tag            = {store_reg[OFF_VLAN_HIGH],
                                            store_reg[OFF_TX_END]}; // R18
  assign CORE_CONFIG.byte_order          = store_reg[OFF_BYTE_ORDER]; // R19
  assign CORE_CONFIG.port_width_select   = port_width_select;

endmodule : paged_mac_register_decoder

`default_nettype wire

// File: testbench.sv
`default_nettype none

module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import mac_regs_pkg::*;

  logic            CLK, RST_B, CS_B, RD_B, WR_B, SD_OE;
  logic [4:0]      ADDR;
  logic [15:0]     SD_IN, SD_OUT, DP_RDATA, DP_WDATA;
  logic            pr, pw, prst, pwk;
  core_status_type st;
  core_config_type cfg;
  int              bad_count, checked, n_pr, n_pw, n_rst, n_wk;
  logic [15:0]     v;

  paged_mac_register_decoder i_paged_mac_register_decoder (.CLK(CLK),
    .RST_B(RST_B), .CS_B(CS_B), .RD_B(RD_B), .WR_B(WR_B), .ADDR(ADDR),
    .SD_IN(SD_IN), .SD_OUT(SD_OUT), .SD_OE(SD_OE), .CORE_STATUS(st),
    .CORE_CONFIG(cfg), .DP_RDATA(DP_RDATA), .DP_WDATA(DP_WDATA),
    .DP_READ_PULSE(pr), .DP_WRITE_PULSE(pw), .SOFT_RESET_PULSE(prst),
    .HOST_WAKEUP_PULSE(pwk));
  host_bus_model host (.clk(CLK), .cs_b(CS_B), .rd_b(RD_B), .wr_b(WR_B),
    .addr(ADDR), .sd_in(SD_IN), .sd_oe(SD_OE), .sd_out(SD_OUT));

  // Clock, and distinct engine status so a wrong mux shows
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  initial begin
    st = '{8'h51, 8'h62, 8'h73, 16'h9584, 8'ha6, 8'hb7, 8'hc8, 8'hd9,
           8'he1, 8'hf2, 8'h00};
    DP_RDATA = 16'h1234;
  end

  // Side pulses counted at the falling edge, clear of their launch edge
  always @(negedge CLK) begin
    if (pr === 1'b1) n_pr++;
    if (pw === 1'b1) n_pw++;
    if (prst === 1'b1) n_rst++;
    if (pwk === 1'b1) n_wk++;
  end

  task automatic check(string n, logic [15:0] g, logic [15:0] e);
    checked++;
    if (g !== e) begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask : check

  task automatic rdc(logic [4:0] a, logic [15:0] e);
    host.rd(a, v);
    check($sformatf("read %h", a), v, e);
  endtask : rdc

  task automatic t_page0;
    logic [4:0] ro[9] = '{5'h04, 5'h05, 5'h06, 5'h08, 5'h09, 5'h0c,
                          5'h0d, 5'h0e, 5'h0f};
    logic [7:0] rv[9] = '{8'h51, 8'h62, 8'h73, 8'h84, 8'h95, 8'ha6,
                          8'hb7, 8'hc8, 8'hd9};
    rdc(5'h00, 16'h0021);
    for (int i = 1; i <= 3; i++) begin
      host.wr(5'(i), 16'h0010 + 16'(i));
      rdc(5'(i), 16'h0010 + 16'(i));
    end
    for (int i = 4; i <= 15; i++) begin
      if (i != 7) host.wr(5'(i), 16'h20 + 16'(i));
    end
    for (int i = 0; i < 9; i++) rdc(ro[i], {8'h00, rv[i]});
    rdc(5'h0a, 16'h0000);
    rdc(5'h0b, 16'h0000);
    check("tx page", {8'h00, cfg.tx_start_page}, 16'h0024);
    check("tx count", cfg.tx_byte_count, 16'h2625);
    check("remote start", cfg.remote_start_addr, 16'h2928);
    check("remote count", cfg.remote_count, 16'h2b2a);
    check("cfgs", {cfg.rx_config, cfg.tx_config}, 16'h2c2d);
    check("dcfg mask", {cfg.data_config, cfg.interrupt_mask}, 16'h2e2f);
    $display("page zero test done");
  endtask : t_page0

  task automatic t_common;
    for (int a = 18; a <= 27; a++) begin
      if (a == 23 || a == 25) continue;
      host.wr(5'(a), 16'(a) + 16'h40);
      rdc(5'(a), 16'(a) + 16'h40);
    end
    host.wr(5'h19, 16'h00ff);
    rdc(5'h19, 16'h000f);
    check("frame size", {4'h0, cfg.max_frame_size}, 16'h0f58);
    host.wr(5'h17, 16'h0077);
    rdc(5'h17, 16'h00e1);
    check("jam", {8'h00, cfg.jam_limit_count}, 16'h0077);
    host.wr(5'h1c, 16'h005a);
    host.wr(5'h1d, 16'h005b);
    rdc(5'h1c, 16'h00f2);
    rdc(5'h1d, 16'h0000);
    check("vlan", cfg.vlan_tag, 16'h5b5a);
    host.wr(5'h1e, 16'h0001);
    rdc(5'h1e, 16'h0000);
    check("order", {8'h00, cfg.byte_order}, 16'h0001);
    $display("common test done");
  endtask : t_common

  task automatic t_pages;
    for (int p = 1; p <= 3; p++) begin
      host.wr(5'h00, 16'(p * 64 + 33));
      rdc(5'h00, 16'(p * 64 + 33));
      host.wr(5'h01, 16'h00ee);
      rdc(5'h01, 16'h0000);
      rdc(5'h12, 16'h0052);
    end
    host.wr(5'h00, 16'h0021);
    rdc(5'h01, 16'h0011);
    $display("page test done");
  endtask : t_pages

  task automatic t_misc;
    @(negedge CLK) st.interrupt_events = 8'h05;
    @(negedge CLK) st.interrupt_events = 8'h00;
    rdc(5'h07, 16'h0005);
    host.wr(5'h07, 16'h0001);
    rdc(5'h07, 16'h0004);
    rdc(5'h10, 16'h0034);
    host.wr(5'h11, 16'habcd);
    check("port byte", DP_WDATA, 16'h00cd);
    host.wr(5'h0e, 16'h0001);
    rdc(5'h11, 16'h1234);
    host.wr(5'h10, 16'hbeef);
    check("port word", DP_WDATA, 16'hbeef);
    check("port pulses", 16'(n_pr * 4 + n_pw), 16'h000a);
    rdc(5'h1f, 16'h0000);
    host.wr(5'h1f, 16'h0001);
    check("reset wake", 16'(n_rst * 4 + n_wk), 16'h0005);
    $display("misc test done");
  endtask : t_misc

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  // Main sequence
  initial begin
    RST_B = 1'b0;
    repeat (5) @(negedge CLK);
    RST_B = 1'b1;
    t_page0();
    t_common();
    t_pages();
    t_misc();
    print_verdict();
  end

  // Watchdog, far beyond the 800 or so cycles needed
  initial begin
    #100us;
    bad_count++;
    print_verdict();
  end

endmodule : testbench

`default_nettype wire
